// File: core/magnetic_sensor_mode_config.sv
/*
  mode and channel configuration bank of a three-axis magnetic sensor,
  with trigger handling and decoded controls for the front end.
  assumes an i2c protocol engine on clk that presents single-byte register
  writes and reads as one-cycle strobes, and a converter on clk that
  reports busy and a done pulse. the alert pin is asynchronous.
*/
`include "mag_cfg_map.svh"
`timescale 1ns/1ps
`default_nettype none

module magnetic_sensor_mode_config (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // register port from the i2c engine
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic reg_rdata_valid,
  // trigger sources
  input wire logic i2c_trig_cmd,
  input wire logic alert_pin_n,
  // converter handshake
  input wire logic conv_busy,
  input wire logic conv_done,
  output logic conv_start,
  output logic trigger_pending,
  // per-axis threshold bytes from the threshold registers
  input wire logic [7:0] axis_threshold_byte_x,
  input wire logic [7:0] axis_threshold_byte_y,
  input wire logic [7:0] axis_threshold_byte_z,
  input wire logic threshold_direction,
  // decoded operating controls
  output logic [1:0] operating_mode,
  output logic noise_current_select,
  output logic glitch_filter_bypass,
  output logic trigger_from_alert,
  // decoded channel plan
  output logic [2:0] channel_mask,
  output logic [5:0] channel_steps,
  output logic [1:0] channel_step_count,
  output logic [2:0] diag_select,
  // decoded threshold controls, x in the low byte
  output logic [2:0] thr_cmp_en,
  output logic [23:0] thr_high,
  output logic [23:0] thr_low,
  output logic [8:0] thr_band_lsb,
  output logic thr_dir_used
);

  // ----------------------------------------
  // channel plan decode
  // ----------------------------------------
  function automatic mag_cfg_pkg::chan_plan_s chan_plan(input logic [3:0] code);
    mag_cfg_pkg::chan_plan_s p;
    p = '0;
    p.diag = `DIAG_NONE;
    if (code == 4'h0) begin
      p.mask = 3'h0;
    end else if (code <= 4'h7) begin
      p.mask = code[2:0];
      p.nsteps = 2'(code[0] + code[1] + code[2]);
    end else if (code == 4'h8) begin
      p.mask = 3'h3;
      p.steps = {`CH_X, `CH_Y, `CH_X};
      p.nsteps = 2'h3;
    end else if (code == 4'h9) begin
      p.mask = 3'h3;
      p.steps = {`CH_Y, `CH_X, `CH_Y};
      p.nsteps = 2'h3;
    end else if (code == 4'ha) begin
      p.mask = 3'h6;
      p.steps = {`CH_Y, `CH_Z, `CH_Y};
      p.nsteps = 2'h3;
    end else if (code == 4'hb) begin
      p.mask = 3'h5;
      p.steps = {`CH_X, `CH_Z, `CH_X};
      p.nsteps = 2'h3;
    end else if (code == 4'hc) begin
      p.mask = 3'h7;
      p.nsteps = 2'h3;
      p.diag = `DIAG_FRONT_POS;
    end else if (code == 4'hd) begin
      p.mask = 3'h7;
      p.nsteps = 2'h3;
      p.diag = `DIAG_FRONT_NEG;
    end else if (code == 4'he) begin
      p.diag = `DIAG_HALL_RES;
    end else begin
      p.diag = `DIAG_HALL_OFS;
    end
    // plain masks list steps from the lowest enabled axis
    if (code != 4'h0 && code <= 4'h7) begin
      p.steps = code[0] ? {4'h0, `CH_X} : (code[1] ? {4'h0, `CH_Y} : {4'h0, `CH_Z});
      if (code == 4'h3) p.steps = {2'h0, `CH_Y, `CH_X};
      if (code == 4'h5) p.steps = {2'h0, `CH_Z, `CH_X};
      if (code == 4'h6) p.steps = {2'h0, `CH_Z, `CH_Y};
      if (code == 4'h7) p.steps = {`CH_Z, `CH_Y, `CH_X};
    end
    return p;
  endfunction : chan_plan

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [7:0] mode_reg_ff;
  logic [7:0] chan_reg_ff;
  logic [7:0] rdata_ff;
  logic rvalid_ff;

  wire logic hit_mode = (reg_addr == `MODE_REG_OFS);
  wire logic hit_chan = (reg_addr == `CHAN_REG_OFS);
  wire logic wr_mode = reg_wr && hit_mode;
  wire logic wr_chan = reg_wr && hit_chan;

  // reserved low nibble of the channel register is never stored
  wire logic [7:0] nxt_chan = reg_wdata & `CHAN_WR_MASK;

  // unmapped reads answer zero
  wire logic [7:0] nxt_rdata = hit_mode ? mode_reg_ff
                             : hit_chan ? chan_reg_ff
                             : 8'h00;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mode_reg_ff <= `MODE_REG_RST;
    end else if (wr_mode) begin
      // reserved mode code is kept but starts nothing
      mode_reg_ff <= reg_wdata;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      chan_reg_ff <= `CHAN_REG_RST;
    end else if (wr_chan) begin
      chan_reg_ff <= nxt_chan;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_ff <= 8'h00;
      rvalid_ff <= 1'b0;
    end else begin
      rvalid_ff <= reg_rd;
      if (reg_rd) rdata_ff <= nxt_rdata;
    end
  end

  // ----------------------------------------
  // field views
  // ----------------------------------------
  wire logic [2:0] scheme = mode_reg_ff[`SCHEME_HI:`SCHEME_LO];
  wire logic [1:0] opm = mode_reg_ff[`OPMODE_HI:`OPMODE_LO];
  wire logic trig_src_alert = mode_reg_ff[`TRIG_SRC_BIT];
  wire logic [3:0] chsel = chan_reg_ff[`CHSEL_HI:`CHSEL_LO];
  wire mag_cfg_pkg::chan_plan_s plan = chan_plan(chsel);

  // ----------------------------------------
  // alert pin synchroniser and edge
  // ----------------------------------------
  logic alert_s1_ff;
  logic alert_s2_ff;
  logic alert_s3_ff;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      alert_s1_ff <= 1'b1;
      alert_s2_ff <= 1'b1;
      alert_s3_ff <= 1'b1;
    end else begin
      alert_s1_ff <= alert_pin_n;
      alert_s2_ff <= alert_s1_ff;
      alert_s3_ff <= alert_s2_ff;
    end
  end

  // trigger is the falling edge; a held-low pin gives one trigger only
  wire logic alert_fall = alert_s3_ff && !alert_s2_ff;

  // ----------------------------------------
  // trigger selection and arbitration
  // ----------------------------------------
  // the unselected source is ignored outright, not queued
  wire logic trig_sel = trig_src_alert ? alert_fall : i2c_trig_cmd;

  logic arb_start;
  logic arb_pending;

  trigger_arbiter u_arb (
    .clk(clk),
    .arst_n(arst_n),
    .op_mode(opm),
    .trig(trig_sel),
    .conv_busy(conv_busy),
    .conv_done(conv_done),
    .conv_start(arb_start),
    .pending(arb_pending)
  );

  // ----------------------------------------
  // threshold shaping per axis
  // ----------------------------------------
  wire logic [23:0] thr_bytes = {axis_threshold_byte_z, axis_threshold_byte_y,
                                 axis_threshold_byte_x};
  logic [2:0] td_en;
  logic [23:0] td_hi;
  logic [23:0] td_lo;
  logic [8:0] td_band;
  logic td_dir;

  genvar ax;
  generate
    for (ax = 0; ax < 3; ax++) begin : g_axis
      if (ax == 0) begin : g_first
        threshold_decode u_td (
          .scheme(scheme),
          .thr_byte(thr_bytes[8*ax +: 8]),
          .dir_in(threshold_direction),
          .cmp_en(td_en[ax]),
          .thr_hi(td_hi[8*ax +: 8]),
          .thr_lo(td_lo[8*ax +: 8]),
          .band_lsb(td_band),
          .dir_used(td_dir)
        );
      end else begin : g_rest
        threshold_decode u_td (
          .scheme(scheme),
          .thr_byte(thr_bytes[8*ax +: 8]),
          .dir_in(threshold_direction),
          .cmp_en(td_en[ax]),
          .thr_hi(td_hi[8*ax +: 8]),
          .thr_lo(td_lo[8*ax +: 8]),
          .band_lsb(),
          .dir_used()
        );
      end
    end
  endgenerate

  // ----------------------------------------
  // output registers
  // ----------------------------------------
  logic conv_start_ff;
  logic pending_ff;
  logic [1:0] opm_ff;
  logic noise_ff;
  logic glitch_ff;
  logic trig_src_ff;
  logic [2:0] mask_ff;
  logic [5:0] steps_ff;
  logic [1:0] nsteps_ff;
  logic [2:0] diag_ff;
  logic [2:0] cmp_en_ff;
  logic [23:0] hi_ff;
  logic [23:0] lo_ff;
  logic [8:0] band_ff;
  logic dir_ff;

  // decoded controls lag the register by one cycle; the converter
  // only samples them when a conversion starts, so this is harmless
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      opm_ff <= 2'h0;
      noise_ff <= 1'b0;
      glitch_ff <= 1'b0;
      trig_src_ff <= 1'b0;
    end else begin
      opm_ff <= opm;
      noise_ff <= mode_reg_ff[`NOISE_BIT];
      glitch_ff <= mode_reg_ff[`GLITCH_BIT];
      trig_src_ff <= trig_src_alert;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mask_ff <= 3'h0;
      steps_ff <= 6'h00;
      nsteps_ff <= 2'h0;
      diag_ff <= `DIAG_NONE;
    end else begin
      mask_ff <= plan.mask;
      steps_ff <= plan.steps;
      nsteps_ff <= plan.nsteps;
      diag_ff <= plan.diag;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cmp_en_ff <= 3'h0;
      hi_ff <= 24'h00_0000;
      lo_ff <= 24'h00_0000;
      band_ff <= 9'h000;
      dir_ff <= 1'b0;
    end else begin
      cmp_en_ff <= td_en;
      hi_ff <= td_hi;
      lo_ff <= td_lo;
      band_ff <= td_band;
      dir_ff <= td_dir;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      conv_start_ff <= 1'b0;
      pending_ff <= 1'b0;
    end else begin
      conv_start_ff <= arb_start;
      pending_ff <= arb_pending;
    end
  end

  // ----------------------------------------
  // port drive
  // ----------------------------------------
  assign reg_rdata = rdata_ff;
  assign reg_rdata_valid = rvalid_ff;
  assign conv_start = conv_start_ff;
  assign trigger_pending = pending_ff;
  assign operating_mode = opm_ff;
  assign noise_current_select = noise_ff;
  assign glitch_filter_bypass = glitch_ff;
  assign trigger_from_alert = trig_src_ff;
  assign channel_mask = mask_ff;
  assign channel_steps = steps_ff;
  assign channel_step_count = nsteps_ff;
  assign diag_select = diag_ff;
  assign thr_cmp_en = cmp_en_ff;
  assign thr_high = hi_ff;
  assign thr_low = lo_ff;
  assign thr_band_lsb = band_ff;
  assign thr_dir_used = dir_ff;

endmodule : magnetic_sensor_mode_config
`default_nettype wire

// File: core/mag_cfg_map.svh
/*
  register offsets, field positions, reset values and codes of the
  mode and channel configuration bank.
  assumes inclusion by bare name from core/ files; definitions only.
*/
`ifndef MAG_CFG_MAP_SVH
`define MAG_CFG_MAP_SVH

// ----------------------------------------
// offsets and reset values
// ----------------------------------------
`define MODE_REG_OFS 8'h01
`define CHAN_REG_OFS 8'h02
`define MODE_REG_RST 8'h00
`define CHAN_REG_RST 8'h00
`define CHAN_WR_MASK 8'hf0

// ----------------------------------------
// field positions
// ----------------------------------------
`define SCHEME_HI 7
`define SCHEME_LO 5
`define NOISE_BIT 4
`define GLITCH_BIT 3
`define TRIG_SRC_BIT 2
`define OPMODE_HI 1
`define OPMODE_LO 0
`define CHSEL_HI 7
`define CHSEL_LO 4

// ----------------------------------------
// codes
// ----------------------------------------
`define SCHEME_SIGNED 3'h0
`define SCHEME_MIRROR 3'h1
`define SCHEME_BAND0 3'h2
`define BAND_BASE_LSB 9'h008
`define CMP_RES_BITS 12
`define CH_X 2'h0
`define CH_Y 2'h1
`define CH_Z 2'h2
`define DIAG_NONE 3'h0
`define DIAG_FRONT_POS 3'h1
`define DIAG_FRONT_NEG 3'h2
`define DIAG_HALL_RES 3'h3
`define DIAG_HALL_OFS 3'h4

`endif

// File: core/mag_cfg_pkg.sv
/*
  types shared by the configuration bank and its helpers.
  assumes nothing beyond a SystemVerilog compiler.
*/
package mag_cfg_pkg;

  typedef enum logic [1:0] {
    OPM_STANDBY = 2'h0,
    OPM_SLEEP = 2'h1,
    OPM_CONT = 2'h2,
    OPM_RSVD = 2'h3
  } op_mode_e;

  // gray along idle -> pend -> run
  typedef enum logic [1:0] {
    CV_IDLE = 2'h0,
    CV_PEND = 2'h1,
    CV_RUN = 2'h3
  } conv_state_e;

  typedef struct packed {
    logic [2:0] mask;
    logic [5:0] steps;
    logic [1:0] nsteps;
    logic [2:0] diag;
  } chan_plan_s;

endpackage : mag_cfg_pkg

// File: core/threshold_decode.sv
/*
  per-axis threshold shaping from the scheme field and one threshold byte.
  assumes inputs are registered by the caller; purely combinational.
*/
`include "mag_cfg_map.svh"
`timescale 1ns/1ps
`default_nettype none

module threshold_decode (
  // configuration
  input wire logic [2:0] scheme,
  input wire logic [7:0] thr_byte,
  input wire logic dir_in,
  // shaped threshold
  output logic cmp_en,
  output logic [7:0] thr_hi,
  output logic [7:0] thr_lo,
  output logic [8:0] band_lsb,
  output logic dir_used
);

  wire logic is_signed = (scheme == `SCHEME_SIGNED);
  wire logic is_mirror = (scheme == `SCHEME_MIRROR);
  wire logic [7:0] mag7 = {1'b0, thr_byte[6:0]};
  wire logic [2:0] band_sh = 3'(scheme - `SCHEME_BAND0);

  assign cmp_en = (thr_byte != 8'h00);
  assign thr_hi = is_mirror ? mag7 : thr_byte;
  assign thr_lo = is_mirror ? 8'(~mag7 + 8'h01) : thr_byte;
  // band counted in 12-bit result LSBs
  assign band_lsb = (is_signed || is_mirror) ? 9'h000
                    : 9'(`BAND_BASE_LSB << band_sh);
  assign dir_used = (is_signed || is_mirror) ? dir_in : 1'b0;

endmodule : threshold_decode
`default_nettype wire

// File: core/trigger_arbiter.sv
/*
  single-conversion trigger arbitration and continuous-mode restart.
  assumes conv_busy and conv_done come from the converter on clk.
*/
`include "mag_cfg_map.svh"
`timescale 1ns/1ps
`default_nettype none

module trigger_arbiter (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // control
  input wire logic [1:0] op_mode,
  input wire logic trig,
  // converter
  input wire logic conv_busy,
  input wire logic conv_done,
  output logic conv_start,
  output logic pending
);

  mag_cfg_pkg::conv_state_e state_ff, nxt_state;
  logic start_ff;

  wire logic standby = (op_mode == mag_cfg_pkg::OPM_STANDBY);
  wire logic cont = (op_mode == mag_cfg_pkg::OPM_CONT);

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      mag_cfg_pkg::CV_IDLE: begin
        if (cont && !conv_busy) nxt_state = mag_cfg_pkg::CV_RUN;
        else if (standby && trig) nxt_state = mag_cfg_pkg::CV_PEND;
      end
      mag_cfg_pkg::CV_PEND: begin
        // extra triggers here are simply not looked at
        if (!standby) nxt_state = mag_cfg_pkg::CV_IDLE;
        else if (!conv_busy) nxt_state = mag_cfg_pkg::CV_RUN;
      end
      mag_cfg_pkg::CV_RUN: begin
        if (conv_done) nxt_state = mag_cfg_pkg::CV_IDLE;
      end
      default: nxt_state = mag_cfg_pkg::CV_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_ff <= mag_cfg_pkg::CV_IDLE;
      start_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      start_ff <= (nxt_state == mag_cfg_pkg::CV_RUN) && (state_ff != mag_cfg_pkg::CV_RUN);
    end
  end

  assign conv_start = start_ff;
  assign pending = (state_ff == mag_cfg_pkg::CV_PEND);

endmodule : trigger_arbiter
`default_nettype wire

// File: sim/mag_cfg_checker.sv
/*
  port-level checks of the mode and channel configuration bank.
  assumes binding to magnetic_sensor_mode_config; single clock domain.
*/
`timescale 1ns/1ps
`default_nettype none

module mag_cfg_checker (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rdata_valid,
  // converter and decoded controls
  input wire logic conv_busy,
  input wire logic conv_start,
  input wire logic trigger_pending,
  input wire logic [7:0] axis_threshold_byte_x,
  input wire logic [1:0] operating_mode,
  input wire logic noise_current_select,
  input wire logic glitch_filter_bypass,
  input wire logic trigger_from_alert,
  input wire logic [2:0] channel_mask,
  input wire logic [2:0] diag_select,
  input wire logic [2:0] thr_cmp_en
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  wire logic wr_mode = reg_wr && reg_addr == 8'h01;
  wire logic wr_chan = reg_wr && reg_addr == 8'h02;
  wire logic rd_other = reg_rd && reg_addr != 8'h01 && reg_addr != 8'h02;

  property p_rd_valid;
    reg_rd |=> reg_rdata_valid;
  endproperty
  a_rd_valid: assert property (p_rd_valid) else $error("read valid missing");
  property p_rd_quiet;
    !reg_rd |=> !reg_rdata_valid;
  endproperty
  a_rd_quiet: assert property (p_rd_quiet) else $error("read valid without read");
  property p_mode_dec;
    wr_mode |-> ##2 {noise_current_select, glitch_filter_bypass, trigger_from_alert,
      operating_mode} == $past(reg_wdata[4:0], 2);
  endproperty
  a_mode_dec: assert property (p_mode_dec) else $error("mode fields wrong");
  property p_chan_mask;
    wr_chan && !reg_wdata[7] |-> ##2 channel_mask == $past(reg_wdata[6:4], 2);
  endproperty
  a_chan_mask: assert property (p_chan_mask) else $error("channel mask wrong");
  property p_front_diag;
    wr_chan && reg_wdata[7:5] == 3'h6 |-> ##2 channel_mask == 3'h7 &&
      diag_select == ($past(reg_wdata[4], 2) ? 3'h2 : 3'h1);
  endproperty
  a_front_diag: assert property (p_front_diag) else $error("front-end check wrong");
  property p_rsvd_nibble;
    reg_rd && reg_addr == 8'h02 |=> reg_rdata[3:0] == 4'h0;
  endproperty
  a_rsvd_nibble: assert property (p_rsvd_nibble) else $error("reserved bits not zero");
  property p_unmapped;
    rd_other |=> reg_rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_cmp_en;
    axis_threshold_byte_x != 8'h00 |=> thr_cmp_en[0];
  endproperty
  a_cmp_en: assert property (p_cmp_en) else $error("x compare not enabled");
  property p_start_pulse;
    conv_start |-> !conv_busy ##1 !conv_start;
  endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("start during run");
  property p_pend_start;
    $rose(trigger_pending) |-> ##[1:300] conv_start;
  endproperty
  a_pend_start: assert property (p_pend_start) else $error("held trigger lost");
endmodule : mag_cfg_checker

`default_nettype wire

// File: sim/conv_model.sv
/*
  behavioural converter: busy for a fixed run, then a done pulse.
  assumes starts arrive only while idle; ext_go models a foreign run.
*/
`timescale 1ns/1ps
`default_nettype none

module conv_model #(
  parameter int RUN_CYC = 12
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // requests
  input wire logic conv_start,
  input wire logic ext_go,
  // status
  output logic conv_busy,
  output logic conv_done
);
  logic [7:0] cnt_ff;
  // done lands with the busy fall, like the real converter
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_ff <= 8'h00;
      conv_busy <= 1'b0;
      conv_done <= 1'b0;
    end else begin
      conv_done <= conv_busy && cnt_ff == 8'h01;
      if (!conv_busy && (conv_start || ext_go)) begin
        conv_busy <= 1'b1;
        cnt_ff <= 8'(RUN_CYC);
      end else if (conv_busy) begin
        cnt_ff <= cnt_ff - 8'h01;
        conv_busy <= cnt_ff != 8'h01;
      end
    end
  end
endmodule : conv_model

`default_nettype wire

// File: sim/magnetic_sensor_mode_config_tb.sv
/*
  register, decode and trigger tests of the configuration bank.
  assumes the converter model and the checker bound below.
*/
`timescale 1ns/1ps
`default_nettype none

module magnetic_sensor_mode_config_tb;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic i2c_trig_cmd = 1'b0;
  logic alert_pin_n = 1'b1;
  logic ext_go = 1'b0;
  logic [7:0] thr_x = 8'h00;
  logic [7:0] thr_z = 8'h00;
  logic thr_dir = 1'b0;
  wire logic [7:0] reg_rdata;
  wire logic reg_rdata_valid, conv_busy, conv_done, conv_start, trigger_pending;
  wire logic [1:0] operating_mode, channel_step_count;
  wire logic noise_current_select, glitch_filter_bypass, trigger_from_alert, thr_dir_used;
  wire logic [2:0] channel_mask, diag_select, thr_cmp_en;
  wire logic [5:0] channel_steps;
  wire logic [23:0] thr_high, thr_low;
  wire logic [8:0] thr_band_lsb;
  int fails = 0;
  int compares = 0;
  int n_start = 0;
  logic [5:0] steps_tab [4] = '{6'h04, 6'h11, 6'h19, 6'h08};

  always #12.5 clk = ~clk;
  // counted off-edge so the registered pulse is settled
  always @(negedge clk) if (conv_start === 1'b1) n_start++;

  magnetic_sensor_mode_config i_dut (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .reg_rdata_valid(reg_rdata_valid), .i2c_trig_cmd(i2c_trig_cmd), .alert_pin_n(alert_pin_n),
    .conv_busy(conv_busy), .conv_done(conv_done), .conv_start(conv_start),
    .trigger_pending(trigger_pending), .axis_threshold_byte_x(thr_x),
    .axis_threshold_byte_y(8'h00), .axis_threshold_byte_z(thr_z),
    .threshold_direction(thr_dir), .operating_mode(operating_mode),
    .noise_current_select(noise_current_select), .glitch_filter_bypass(glitch_filter_bypass),
    .trigger_from_alert(trigger_from_alert), .channel_mask(channel_mask),
    .channel_steps(channel_steps), .channel_step_count(channel_step_count),
    .diag_select(diag_select), .thr_cmp_en(thr_cmp_en), .thr_high(thr_high),
    .thr_low(thr_low), .thr_band_lsb(thr_band_lsb), .thr_dir_used(thr_dir_used));
  conv_model #(.RUN_CYC(12)) i_conv (.clk(clk), .arst_n(arst_n), .conv_start(conv_start),
    .ext_go(ext_go), .conv_busy(conv_busy), .conv_done(conv_done));

  task automatic tick(input int n = 1);
    repeat (n) @(posedge clk);
    #2;
  endtask : tick
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    tick();
    reg_wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    reg_rd = 1'b1;
    reg_addr = a;
    tick();
    reg_rd = 1'b0;
    chk(24'({reg_rdata_valid, reg_rdata}), 24'({1'b1, exp}));
    // one idle edge so back-to-back reads never rewrite the strobe at once
    tick();
  endtask : rd
  task automatic trig();
    i2c_trig_cmd = 1'b1;
    tick();
    i2c_trig_cmd = 1'b0;
  endtask : trig
  task automatic summarize();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : summarize

  // ----------------------------------------
  // watchdog
  // ----------------------------------------
  initial begin
    #100000;
    fails++;
    summarize();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    tick(3);
    arst_n = 1'b1;
    tick();
    rd(8'h01, 8'h00);
    rd(8'h02, 8'h00);
    thr_x = 8'h85;
    thr_z = 8'h7f;
    thr_dir = 1'b1;
    // sleep keeps the converter quiet so later start counts stay exact
    wr(8'h01, 8'hfd);
    tick();
    chk(24'({noise_current_select, glitch_filter_bypass, trigger_from_alert, operating_mode}),
      24'h00_001d);
    rd(8'h01, 8'hfd);
    wr(8'h05, 8'h00);
    rd(8'h07, 8'h00);
    rd(8'h01, 8'hfd);
    for (int c = 0; c < 16; c++) begin
      wr(8'h02, 8'({c[3:0], 4'hf}));
      tick();
      if (c < 8) chk(24'({channel_mask, diag_select}), 24'({c[2:0], 3'h0}));
      else if (c < 12) chk(24'({channel_step_count, channel_steps}), 24'({2'h3, steps_tab[c-8]}));
      else chk(24'({channel_mask, diag_select}), 24'({(c < 14) ? 3'h7 : 3'h0, 3'(c - 11)}));
      rd(8'h02, 8'({c[3:0], 4'h0}));
    end
    for (int s = 0; s < 8; s++) begin
      wr(8'h01, 8'({s[2:0], 5'h00}));
      tick();
      chk(24'(thr_cmp_en), 24'h00_0005);
      chk(24'({thr_dir_used, thr_band_lsb}), 24'({s < 2, (s < 2) ? 9'h000 : 9'(9'h008 << (s - 2))}));
      chk(24'({thr_high[7:0], thr_low[7:0]}), 24'((s == 1) ? 16'h05fb : 16'h8585));
    end
    trig();
    tick(2);
    trig();
    tick(40);
    chk(24'(n_start), 24'h00_0001);
    ext_go = 1'b1;
    tick();
    ext_go = 1'b0;
    tick(2);
    trig();
    tick(3);
    chk(24'({trigger_pending, 8'(n_start)}), 24'h00_0101);
    tick(40);
    chk(24'(n_start), 24'h00_0002);
    wr(8'h01, 8'h01);
    trig();
    tick(30);
    chk(24'(n_start), 24'h00_0002);
    wr(8'h01, 8'h04);
    trig();
    tick(30);
    chk(24'(n_start), 24'h00_0002);
    alert_pin_n = 1'b0;
    tick(30);
    alert_pin_n = 1'b1;
    chk(24'(n_start), 24'h00_0003);
    wr(8'h01, 8'h02);
    tick(60);
    chk(24'(n_start > 4), 24'h00_0001);
    wr(8'h01, 8'h00);
    tick(30);
    summarize();
  end
endmodule : magnetic_sensor_mode_config_tb

bind magnetic_sensor_mode_config mag_cfg_checker i_chk (.clk(clk), .arst_n(arst_n),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .reg_rdata_valid(reg_rdata_valid), .conv_busy(conv_busy),
  .conv_start(conv_start), .trigger_pending(trigger_pending),
  .axis_threshold_byte_x(axis_threshold_byte_x), .operating_mode(operating_mode),
  .noise_current_select(noise_current_select), .glitch_filter_bypass(glitch_filter_bypass),
  .trigger_from_alert(trigger_from_alert), .channel_mask(channel_mask),
  .diag_select(diag_select), .thr_cmp_en(thr_cmp_en));

`default_nettype wire
